// *** src/bfc_host.sv ***
// host controller driving a boot block flash over its pins
module bfc_host
  import bfc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [19:0] fl_addr,
  input wire logic [15:0] fl_dq_in,
  output logic [15:0] fl_dq_out,
  output logic fl_dq_oe,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic fl_reset_powerdown_n,
  output logic fl_byte_n,
  output logic fl_unlock,
  output logic fl_vpp_en
);
  import bfc_pkg::*;
  typedef enum logic [2:0] {
    S_IDLE, S_CMD1, S_CMD2, S_RD, S_POLL, S_FFH
  } bfc_state_e;
  bfc_state_e state_ff;
  logic [2:0] op_ff;
  logic [19:0] addr_ff;
  logic [15:0] wdata_ff;
  logic [3:0] cfg_ff;
  logic [7:0] fstat_ff;
  logic [15:0] rdata_ff;
  logic pend_ff;
  logic [7:0] prev_code_ff;
  logic cyc_done;
  logic [15:0] cyc_rdata;

  // register bus decode
  wire busy = state_ff != S_IDLE;
  wire sel_cmd = avs_address == OFS_CMD;
  wire sel_addr = avs_address == OFS_ADDR;
  wire sel_wdata = avs_address == OFS_WDATA;
  wire sel_cfg = avs_address == OFS_CFG;
  wire sel_stat = avs_address == OFS_STAT;
  wire sel_rdata = avs_address == OFS_RDATA;
  wire cmd_block = avs_write && sel_cmd && busy;
  wire accept = (avs_read || avs_write) && avs_waitrequest && !cmd_block;
  wire wr_take = avs_write && !avs_waitrequest;
  wire start = wr_take && sel_cmd && avs_writedata[2:0] <= OP_LAST;
  wire err_any = fstat_ff[ST_SUPPLY_ERR] || fstat_ff[ST_PROG_ERR]
    || fstat_ff[ST_ERASE_ERR];
  wire [31:0] rd_mux =
    sel_cmd ? {29'h0, op_ff} :
    sel_addr ? {12'h000, addr_ff} :
    sel_wdata ? {16'h0000, wdata_ff} :
    sel_cfg ? {28'h0, cfg_ff} :
    sel_stat ? {16'h0000, fstat_ff, 6'h00, err_any, busy} :
    sel_rdata ? {16'h0000, rdata_ff} : 32'h0;

  // first write code of each operation but OP_READ, which writes none
  wire [7:0] code1 =
    op_ff == OP_PROG ? CMD_PROG_SETUP :
    op_ff == OP_ERASE ? CMD_ERASE_SETUP :
    op_ff == OP_ID ? CMD_READ_ID :
    op_ff == OP_STATUS ? CMD_READ_STATUS : CMD_READ_ARRAY;
  wire [15:0] code2 = op_ff == OP_ERASE ? {8'h00, CMD_ERASE_CONFIRM} : wdata_ff;
  // identify reads keep all address lines but A0 low
  wire [19:0] rd_addr = op_ff == OP_ID ? {19'h0, addr_ff[0]} : addr_ff;
  wire cyc_go = busy && !pend_ff;
  wire cyc_write = state_ff == S_CMD1 || state_ff == S_CMD2
    || state_ff == S_FFH;
  wire [19:0] cyc_addr = state_ff == S_RD ? rd_addr : addr_ff;
  wire [15:0] cyc_wdata =
    state_ff == S_CMD1 ? {8'h00, code1} :
    state_ff == S_CMD2 ? code2 : {8'h00, CMD_READ_ARRAY};
  wire ready = cyc_rdata[ST_READY];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= !accept;
      if (accept) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_ff <= 20'h00000;
      wdata_ff <= 16'h0000;
      cfg_ff <= CFG_RST;
    end else if (wr_take) begin
      if (sel_addr) addr_ff <= avs_writedata[19:0];
      if (sel_wdata) wdata_ff <= avs_writedata[15:0];
      if (sel_cfg) cfg_ff <= avs_writedata[3:0];
    end
  end

  // pins steered by config
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fl_reset_powerdown_n <= 1'b0;
      fl_byte_n <= 1'b1;
      fl_unlock <= 1'b0;
      fl_vpp_en <= 1'b0;
    end else begin
      fl_reset_powerdown_n <= !cfg_ff[CFG_PDOWN];
      fl_byte_n <= !cfg_ff[CFG_BYTE];
      fl_unlock <= cfg_ff[CFG_UNLOCK];
      fl_vpp_en <= cfg_ff[CFG_VPP];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pend_ff <= 1'b0;
      prev_code_ff <= 8'h00;
    end else begin
      if (cyc_go) pend_ff <= 1'b1;
      else if (cyc_done) pend_ff <= 1'b0;
      if (cyc_go && cyc_write) prev_code_ff <= cyc_wdata[7:0];
    end
  end

  // operation sequencer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= S_IDLE;
      op_ff <= OP_READ;
      fstat_ff <= 8'h00;
      rdata_ff <= 16'h0000;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (start) begin
            op_ff <= avs_writedata[2:0];
            state_ff <= avs_writedata[2:0] == OP_READ ? S_RD : S_CMD1;
          end
        end
        S_CMD1: begin
          if (cyc_done) begin
            if (op_ff == OP_PROG || op_ff == OP_ERASE) state_ff <= S_CMD2;
            else if (op_ff == OP_ARRAY) state_ff <= S_IDLE;
            else state_ff <= S_RD;
          end
        end
        S_CMD2: if (cyc_done) state_ff <= S_POLL;
        S_RD: begin
          if (cyc_done) begin
            rdata_ff <= cyc_rdata;
            state_ff <= S_IDLE;
          end
        end
        // poll status until the device engine is ready
        S_POLL: begin
          if (cyc_done && ready) begin
            fstat_ff <= cyc_rdata[7:0];
            state_ff <= S_FFH;
          end
        end
        // back to array reads after program or erase
        S_FFH: if (cyc_done) state_ff <= S_IDLE;
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  bfc_cycle u_cycle (
    .mclk(mclk),
    .rst(rst),
    .go(cyc_go),
    .is_write(cyc_write),
    .addr(state_ff == S_POLL ? addr_ff : cyc_addr),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_dq_in(fl_dq_in),
    .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe),
    .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n)
  );

  erase_seq_a: assert property (@(posedge mclk) disable iff (rst)
    state_ff == S_CMD2 && op_ff == OP_ERASE && cyc_go
    |-> cyc_wdata[7:0] == CMD_ERASE_CONFIRM
    && prev_code_ff == CMD_ERASE_SETUP)
    else $error("erase confirm not right after setup");
  prog_seq_a: assert property (@(posedge mclk) disable iff (rst)
    state_ff == S_CMD2 && op_ff == OP_PROG && cyc_go
    |-> cyc_wdata == wdata_ff && prev_code_ff == CMD_PROG_SETUP)
    else $error("program data not right after setup");
  read_array_a: assert property (@(posedge mclk) disable iff (rst)
    state_ff == S_POLL && cyc_done && ready
    |=> state_ff == S_FFH && cyc_go && cyc_wdata[7:0] == CMD_READ_ARRAY)
    else $error("no read array after program or erase");
  id_addr_a: assert property (@(posedge mclk) disable iff (rst)
    state_ff == S_RD && op_ff == OP_ID && cyc_go
    |-> ##2 fl_addr[19:1] == 19'h0)
    else $error("identify read with high address lines");
  bus_answer_a: assert property (@(posedge mclk) disable iff (rst)
    avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("register read not answered next cycle");
  erase_cov: cover property (@(posedge mclk) disable iff (rst)
    state_ff == S_FFH && op_ff == OP_ERASE && cyc_done);
  prog_cov: cover property (@(posedge mclk) disable iff (rst)
    state_ff == S_FFH && op_ff == OP_PROG && cyc_done);
  id_cov: cover property (@(posedge mclk) disable iff (rst)
    state_ff == S_RD && op_ff == OP_ID && cyc_done);
endmodule : bfc_host

// *** src/bfc_pkg.sv ***
// constants for the boot block flash host controller
package bfc_pkg;
  // clock and bus cycle timing
  localparam int CLK_NS = 40;
  localparam int T_WP_NS = 70;
  localparam int T_ACC_NS = 120;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 2;
  localparam int RD_CYC = ACC_CYC + SYNC_CYC;
  // flash command codes
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  // flash status byte bits
  localparam int ST_READY = 7;
  localparam int ST_ERASE_ERR = 5;
  localparam int ST_PROG_ERR = 4;
  localparam int ST_SUPPLY_ERR = 3;
  // register byte offsets
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_ADDR = 5'h04;
  localparam logic [4:0] OFS_WDATA = 5'h08;
  localparam logic [4:0] OFS_CFG = 5'h0c;
  localparam logic [4:0] OFS_STAT = 5'h10;
  localparam logic [4:0] OFS_RDATA = 5'h14;
  // config bits and reset value
  localparam int CFG_BYTE = 0;
  localparam int CFG_UNLOCK = 1;
  localparam int CFG_VPP = 2;
  localparam int CFG_PDOWN = 3;
  localparam logic [3:0] CFG_RST = 4'h0;
  // operations written to the command register
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROG = 3'h1;
  localparam logic [2:0] OP_ERASE = 3'h2;
  localparam logic [2:0] OP_ARRAY = 3'h3;
  localparam logic [2:0] OP_ID = 3'h4;
  localparam logic [2:0] OP_STATUS = 3'h5;
  localparam logic [2:0] OP_LAST = 3'h5;
endpackage : bfc_pkg

// *** src/bfc_cycle.sv ***
// one asynchronous flash bus cycle: a strobed write or a timed read
module bfc_cycle
  import bfc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic go,
  input wire logic is_write,
  input wire logic [19:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  input wire logic [15:0] fl_dq_in,
  output logic [19:0] fl_addr,
  output logic [15:0] fl_dq_out,
  output logic fl_dq_oe,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n
);
  typedef enum logic [1:0] {C_IDLE, C_SET, C_STB, C_HOLD} bfc_cyc_e;
  bfc_cyc_e st_ff;
  logic [3:0] cnt_ff;
  logic wr_ff;
  logic [15:0] sync1_ff;
  logic [15:0] sync2_ff;
  wire strobe_end = cnt_ff == 4'(wr_ff ? WP_CYC - 1 : RD_CYC - 1);

  // pin data passes two flops before use
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 16'h0000;
      sync2_ff <= 16'h0000;
    end else begin
      sync1_ff <= fl_dq_in;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= C_IDLE;
      cnt_ff <= 4'h0;
      wr_ff <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      fl_addr <= 20'h00000;
      fl_dq_out <= 16'h0000;
      fl_dq_oe <= 1'b0;
      fl_ce_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_we_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (st_ff)
        C_IDLE: begin
          fl_ce_n <= 1'b1;
          fl_dq_oe <= 1'b0;
          if (go) begin
            wr_ff <= is_write;
            fl_addr <= addr;
            fl_dq_out <= wdata;
            st_ff <= C_SET;
          end
        end
        // chip select first, data driven only for writes
        C_SET: begin
          fl_ce_n <= 1'b0;
          fl_dq_oe <= wr_ff;
          cnt_ff <= 4'h0;
          st_ff <= C_STB;
        end
        // read strobes output enable, write strobes write line
        C_STB: begin
          fl_we_n <= ~wr_ff;
          fl_oe_n <= wr_ff;
          cnt_ff <= cnt_ff + 4'h1;
          if (strobe_end) begin
            st_ff <= C_HOLD;
          end
        end
        // rising write strobe latches, data still held
        C_HOLD: begin
          fl_we_n <= 1'b1;
          fl_oe_n <= 1'b1;
          rdata <= sync2_ff;
          done <= 1'b1;
          st_ff <= C_IDLE;
        end
        default: st_ff <= C_IDLE;
      endcase
    end
  end

  we_strobe_a: assert property (@(posedge mclk) disable iff (rst)
    !fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe)
    else $error("write strobe without select or driven data");
  rd_float_a: assert property (@(posedge mclk) disable iff (rst)
    !fl_oe_n |-> !fl_dq_oe && fl_we_n && !fl_ce_n)
    else $error("read with data lines driven");
  we_width_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(fl_we_n) |=> !fl_we_n)
    else $error("write strobe too short");
endmodule : bfc_cycle

// *** tb/bfc_flash_model.sv ***
// behavioural flash device on the far side of the host controller
module bfc_flash_model
  import bfc_pkg::*;
#(
  // id codes are arbitrary
  parameter logic [7:0] MAKER_ID = 8'h5a,
  parameter logic [7:0] DEVICE_ID = 8'h3c,
  parameter logic [19:0] BOOT_TOP = 20'h01fff,
  parameter int BUSY_NS = 600
)(
  input wire logic [19:0] fl_addr,
  input wire logic [15:0] fl_dq_out,
  input wire logic fl_dq_oe,
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic fl_reset_powerdown_n,
  input wire logic fl_byte_n,
  input wire logic fl_unlock,
  input wire logic fl_vpp_en,
  output logic [15:0] fl_dq_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [logic [19:0]];
  logic [7:0] stat = 8'h80;
  logic [7:0] prev = 8'hff;
  logic [1:0] mode = 2'h0;
  logic [15:0] rd_val;
  logic [15:0] hold = 16'h0;
  int wr_n = 0;
  // undriven lines read back inverted, write needs output enable high
  wire [15:0] din = fl_dq_oe ? fl_dq_out : ~fl_dq_out;
  wire [7:0] cmd = din[7:0];
  wire wsel = !fl_ce_n && fl_oe_n;
  wire boot = fl_addr <= BOOT_TOP;
  wire ok = fl_vpp_en && (!boot || fl_unlock);
  wire rd_en = fl_reset_powerdown_n && !fl_ce_n && !fl_oe_n && fl_we_n;
  task automatic op_end(input int eb);
    prev = 8'hff;
    mode = 2'h2;
    stat = ok ? 8'h00 : 8'h80 | (8'h01 << eb) | (fl_vpp_en ? 8'h0 : 8'h08);
    wr_n++;
  endtask : op_end
  always @(posedge fl_we_n or negedge fl_reset_powerdown_n) begin
    if (!fl_reset_powerdown_n) begin
      stat = 8'h80;
      mode = 2'h0;
      prev = 8'hff;
    end else if (wsel && !stat[7]) begin
      if (cmd == CMD_READ_STATUS) mode = 2'h2;
    end else if (wsel && prev == CMD_ERASE_SETUP
                 && cmd == CMD_ERASE_CONFIRM) begin
      if (ok) foreach (mem[k]) begin
        if ((k <= BOOT_TOP) == boot && (k >> 16) == (fl_addr >> 16))
          mem[k] = 16'hffff;
      end
      op_end(5);
    end else if (wsel && (prev == CMD_PROG_SETUP || prev == 8'h10)) begin
      if (ok) mem[fl_addr] = (mem.exists(fl_addr) ? mem[fl_addr] : 16'hffff)
        & (fl_byte_n ? din : {8'hff, din[7:0]});
      op_end(4);
    end else if (wsel) begin
      mode = cmd == CMD_READ_ARRAY ? 2'h0 : cmd == CMD_READ_ID ? 2'h1 : 2'h2;
      prev = cmd;
    end
  end
  always @(wr_n) if (stat == 8'h00) stat <= #BUSY_NS 8'h80;
  always @(fl_addr or mode or stat or wr_n) begin
    case (mode)
      2'h0: rd_val = mem.exists(fl_addr) ? mem[fl_addr] : 16'hffff;
      2'h1: rd_val = fl_addr[19:1] != 19'h0 ? 16'hdead
        : {8'h00, fl_addr[0] ? DEVICE_ID : MAKER_ID};
      default: rd_val = {8'h00, stat};
    endcase
  end
  always @(rd_en or rd_val) if (rd_en) hold = rd_val;
  assign fl_dq_in = rd_en ? rd_val : ~hold;
endmodule : bfc_flash_model

// *** tb/bfc_host_tb_top.sv ***
// self-checking bench for the flash host controller
module bfc_host_tb_top
  import bfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MAKER = 8'h5a;
  localparam logic [7:0] DEV = 8'h3c;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [19:0] fl_addr;
  logic [15:0] fl_dq_in;
  logic [15:0] fl_dq_out;
  logic fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n;
  logic fl_reset_powerdown_n, fl_byte_n, fl_unlock, fl_vpp_en;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  bfc_host u_bfc_host (.mclk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .fl_addr, .fl_dq_in,
    .fl_dq_out, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n,
    .fl_reset_powerdown_n, .fl_byte_n, .fl_unlock, .fl_vpp_en);
  bfc_flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEV)) u_bfc_flash_model (
    .fl_addr, .fl_dq_out, .fl_dq_oe, .fl_ce_n, .fl_oe_n, .fl_we_n,
    .fl_reset_powerdown_n, .fl_byte_n, .fl_unlock, .fl_vpp_en, .fl_dq_in);
  initial forever #20 mclk = ~mclk;
  task automatic end_sim();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : av_wr
  task automatic av_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : av_rd
  task automatic rc(input string nm, input logic [4:0] a, logic [31:0] e);
    logic [31:0] v;
    av_rd(a, v);
    chk(nm, e, v);
  endtask : rc
  task automatic op(input logic [2:0] o, logic [19:0] a, logic [15:0] d);
    logic [31:0] v;
    av_wr(OFS_ADDR, {12'h0, a});
    av_wr(OFS_WDATA, {16'h0, d});
    av_wr(OFS_CMD, {29'h0, o});
    v = 32'h1;
    for (int i = 0; i < 100 && v[0] !== 1'b0; i++) av_rd(OFS_STAT, v);
    chk("busy", 32'h0, {31'h0, v[0]});
  endtask : op
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rc("cfg", OFS_CFG, {28'h0, CFG_RST});
    rc("stat", OFS_STAT, 32'h0);
    rc("hole", 5'h18, 32'h0);
    op(OP_READ, 20'h30000, 16'h0);
    rc("fresh", OFS_RDATA, 32'hffff);
    av_wr(OFS_CFG, 32'h4);
    op(OP_PROG, 20'h10000, 16'ha5c3);
    rc("prog st", OFS_STAT, 32'h8000);
    rc("wdata rb", OFS_WDATA, 32'ha5c3);
    rc("addr rb", OFS_ADDR, 32'h10000);
    op(OP_READ, 20'h10000, 16'h0);
    rc("prog rd", OFS_RDATA, 32'ha5c3);
    op(OP_PROG, 20'h00010, 16'h1234);
    rc("lock st", OFS_STAT, 32'h9002);
    av_wr(OFS_CFG, 32'h6);
    op(OP_PROG, 20'h00010, 16'h1234);
    rc("boot st", OFS_STAT, 32'h8000);
    av_wr(OFS_ADDR, 32'h20008);
    av_wr(OFS_CMD, {29'h0, OP_PROG});
    av_wr(OFS_CMD, {29'h0, OP_STATUS});
    op(OP_ARRAY, 20'h20008, 16'h0);
    rc("queued", OFS_RDATA, 32'h80);
    op(OP_READ, 20'h20008, 16'h0);
    rc("prog2", OFS_RDATA, 32'h1234);
    op(OP_ERASE, 20'h10000, 16'h0);
    rc("erase st", OFS_STAT, 32'h8000);
    op(OP_READ, 20'h10000, 16'h0);
    rc("erased", OFS_RDATA, 32'hffff);
    op(OP_READ, 20'h00010, 16'h0);
    rc("kept", OFS_RDATA, 32'h1234);
    av_wr(OFS_CFG, 32'h5);
    op(OP_PROG, 20'h20004, 16'h5a77);
    op(OP_READ, 20'h20004, 16'h0);
    rc("byte wr", OFS_RDATA, 32'hff77);
    av_wr(OFS_CFG, 32'h4);
    op(OP_ERASE, 20'h00000, 16'h0);
    rc("lock er", OFS_STAT, 32'ha002);
    av_wr(OFS_CFG, 32'h0);
    op(OP_PROG, 20'h20000, 16'h0);
    rc("supply", OFS_STAT, 32'h9802);
    op(OP_ID, 20'h00000, 16'h0);
    rc("maker", OFS_RDATA, {24'h0, MAKER});
    op(OP_ID, 20'h12341, 16'h0);
    rc("device", OFS_RDATA, {24'h0, DEV});
    op(OP_STATUS, 20'h0, 16'h0);
    rc("st rd", OFS_RDATA, 32'h98);
    rc("last op", OFS_CMD, {29'h0, OP_STATUS});
    op(OP_ARRAY, 20'h0, 16'h0);
    op(OP_READ, 20'h00010, 16'h0);
    rc("array", OFS_RDATA, 32'h1234);
    av_wr(OFS_CFG, 32'h9);
    repeat (2) @(posedge mclk);
    chk("pdown", 32'h0, {31'h0, fl_reset_powerdown_n});
    chk("byte", 32'h0, {31'h0, fl_byte_n});
    av_wr(OFS_CFG, 32'h0);
    op(OP_STATUS, 20'h0, 16'h0);
    rc("cleared", OFS_RDATA, 32'h80);
    end_sim();
  end
endmodule : bfc_host_tb_top
